// file: src/mcs_pkg.sv
// Constants shared by the memory control and status register block
// Functional notes
// - control three bit 31 is read-only OR of its sticky error bits
// - control four bit 31 ORs its error bits and the block-state error log
// - nonvolatile writes start only while the update-permit bit is set
// - a refused nonvolatile write sets a sticky bit, write one clears, resets zero
// - seven sticky internal fault bits, cleared by writing ones
// - trigger enable bit acts per trigger config bit 14 (level or one-shot)
// - fifteen-bit read/write trigger configuration field in control three
// - five-bit read/write memory size upper extension in control four
// - two-bit DRAM kind and population bit, read/write, reset zero
// - block read-modify-write check error sets a write-one-clear bit
// - bus protocol violation sets write-one-clear ownership sequence error
// - direct block-state access via port enable and two-bit mode with address register
// - block address register holds bits 31:5, low five bits read zero
// - nonvolatile access register holds eleven-bit address, data byte, start bits
// - data words get single-bit correction and double-bit detection
// - an all-ones or all-zeros code word counts as uncorrectable
// - each six-bit state/commander entry carries five check bits, eleven-bit transfers
// - block-state check bits depend on entry value and block address
// - timeout register logs timed-out command and holds a timeout limit
package mcs_pkg;
	// Register byte offsets in node space
	localparam logic [7:0] OFF_CTL3 = 8'h5C;
	localparam logic [7:0] OFF_CTL4 = 8'h60;
	localparam logic [7:0] OFF_BSDIRECT = 8'h68;
	localparam logic [7:0] OFF_BSTARGET = 8'h6C;
	localparam logic [7:0] OFF_NVCTL = 8'h70;
	localparam logic [7:0] OFF_TMO = 8'h74;
	// Control three fields
	localparam int C3_PERMIT = 30;
	localparam int C3_BADNV = 29;
	localparam int C3_FLT_HI = 22;
	localparam int C3_FLT_LO = 16;
	localparam int C3_TRIGEN = 15;
	localparam int C3_TRIGCFG_HI = 14;
	// Control four fields
	localparam int C4_DIAG = 30;
	localparam int C4_CHKDIS = 29;
	localparam int C4_SIZE_HI = 22;
	localparam int C4_SIZE_LO = 18;
	localparam int C4_KIND_HI = 17;
	localparam int C4_KIND_LO = 16;
	localparam int C4_POP = 15;
	localparam int C4_RMWERR = 14;
	localparam int C4_OWNSEQ = 11;
	localparam int C4_CODE_HI = 10;
	localparam int C4_CODE_LO = 9;
	localparam int C4_ID_HI = 8;
	localparam int C4_ID_LO = 5;
	localparam int C4_CHK_HI = 4;
	// Direct block-state control, address and nonvolatile access fields
	localparam int BS_PE = 31;
	localparam int BS_MODE_HI = 30;
	localparam int BS_MODE_LO = 29;
	localparam int BA_LO = 5;
	localparam int NV_WSTART = 31;
	localparam int NV_RSTART = 30;
	localparam int NV_ADDR_HI = 26;
	localparam int NV_ADDR_LO = 16;
	localparam int NV_DATA_HI = 7;
	// Timeout register fields
	localparam int TO_FLAG = 31;
	localparam int TO_LIM_HI = 15;
	localparam int TO_LIM_LO = 8;
	// Reset values
	localparam logic [14:0] TRIGCFG_RST = 15'h0000;
	localparam logic [7:0] TO_LIM_RST = 8'hFF;
	// Direct block-state access modes
	typedef enum logic [1:0] {
		BSM_OFF = 2'b00,
		BSM_READ = 2'b01,
		BSM_WRITE = 2'b10,
		BSM_SPARE = 2'b11
	} mcs_bsmode_t;
	// Access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BS = 2'b01,
		ST_NV = 2'b10
	} mcs_state_t;
endpackage : mcs_pkg

// file: src/mcs_ecc_if.sv
// Signals between the register block and its check-code unit
`timescale 1ns/1ps
`default_nettype none
interface mcs_ecc_if;
	logic [31:0] dWrWord;
	logic [6:0]  dWrChk;
	logic [31:0] dRdWord;
	logic [6:0]  dRdChk;
	logic [31:0] dFixed;
	logic        dSingle;
	logic        dUncorr;
	logic [5:0]  bsGenValue;
	logic [26:0] bsGenAddr;
	logic [4:0]  bsGenChk;
	logic [10:0] rmwEntry;
	logic [26:0] rmwAddr;
	logic        bsChkErr;
	modport ecc (input dWrWord, dRdWord, dRdChk, bsGenValue, bsGenAddr, rmwEntry, rmwAddr,
		output dWrChk, dFixed, dSingle, dUncorr, bsGenChk, bsChkErr);
	modport ctl (output dWrWord, dRdWord, dRdChk, bsGenValue, bsGenAddr, rmwEntry, rmwAddr,
		input dWrChk, dFixed, dSingle, dUncorr, bsGenChk, bsChkErr);
endinterface : mcs_ecc_if
`default_nettype wire

// file: src/mcs_ecc.sv
// Check-code generation and checking for data words and block-state entries
`timescale 1ns/1ps
`default_nettype none
module mcs_ecc (
	mcs_ecc_if.ecc eb // Check-code signals
);
	// Code-word position of data bit idx (skips powers of two)
	function automatic logic [5:0] dataPos(input int idx);
		int cnt;
		logic [5:0] pos;
		cnt = 0;
		pos = 6'h00;
		for (int k = 3; k < 40; k++) begin
			if ((k & (k - 1)) != 0) begin
				if (cnt == idx) pos = 6'(k);
				cnt++;
			end
		end
		return pos;
	endfunction : dataPos

	// Hamming syndrome contribution of a data word
	function automatic logic [5:0] hamSyn(input logic [31:0] d);
		logic [5:0] s;
		s = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (d[i]) s = s ^ dataPos(i);
		end
		return s;
	endfunction : hamSyn

	// Flip the data bit named by the syndrome
	function automatic logic [31:0] fixWord(input logic [31:0] d, input logic [5:0] syn);
		logic [31:0] f;
		f = d;
		for (int i = 0; i < 32; i++) begin
			if (dataPos(i) == syn) f[i] = ~d[i];
		end
		return f;
	endfunction : fixWord

	// Block-state check: value Hamming plus folded block address
	function automatic logic [4:0] bsCheck(input logic [5:0] v, input logic [26:0] a);
		logic [4:0] c;
		logic [5:0] p;
		c = 5'h00;
		for (int i = 0; i < 6; i++) begin
			p = dataPos(i);
			if (v[i]) c[3:0] = c[3:0] ^ p[3:0];
		end
		c[4] = ^{v, c[3:0]};
		for (int i = 0; i < 27; i++) begin
			c[i % 5] = c[i % 5] ^ a[i];
		end
		return c;
	endfunction : bsCheck

	logic [5:0] rdSyn;
	logic       rdOdd;
	logic       rdFlat;
	logic [5:0] wrSyn;

	// Data word generation and checking
	// single fix, double detect
	assign wrSyn = hamSyn(eb.dWrWord);
	assign eb.dWrChk = {^{eb.dWrWord, wrSyn}, wrSyn};
	assign rdSyn = hamSyn(eb.dRdWord) ^ eb.dRdChk[5:0];
	assign rdOdd = ^{eb.dRdWord, eb.dRdChk};
	assign eb.dFixed = rdOdd ? fixWord(eb.dRdWord, rdSyn) : eb.dRdWord;
	assign rdFlat = (&{eb.dRdWord, eb.dRdChk}) || !(|{eb.dRdWord, eb.dRdChk});
	assign eb.dSingle = rdOdd && !rdFlat && (rdSyn <= 6'h26);
	assign eb.dUncorr = rdFlat || (!rdOdd && (rdSyn != 6'h00)) || (rdOdd && (rdSyn > 6'h26));

	// Block-state entry generation and checking
	// value and address
	assign eb.bsGenChk = bsCheck(eb.bsGenValue, eb.bsGenAddr);
	assign eb.bsChkErr = bsCheck(eb.rmwEntry[10:5], eb.rmwAddr) != eb.rmwEntry[4:0];
endmodule : mcs_ecc
`default_nettype wire

// file: src/mcs_regs.sv
// Memory control and status registers with direct block-state and nonvolatile access
`timescale 1ns/1ps
`default_nettype none
module mcs_regs (
	input  wire logic        sys_clk,         // System clock
	input  wire logic        resetn,          // Async reset, active low
	input  wire logic [7:0]  regAddr,         // Node-space byte offset
	input  wire logic        regWrEn,         // Register write strobe
	input  wire logic        regRdEn,         // Register read strobe
	input  wire logic [31:0] regWrData,       // Write data
	output logic      [31:0] regRdData,       // Read data, registered
	output logic             regRdValid,      // Read data valid pulse
	input  wire logic [6:0]  faultSet,        // Internal fault pulses
	input  wire logic        protoViolation,  // Bus protocol violation pulse
	input  wire logic        becErrPending,   // Block-state error log summary
	input  wire logic [13:0] trigCond,        // Trigger conditions
	output logic             trigPulse,       // Trigger output
	output logic      [4:0]  memSizeUpper,    // Memory size extension
	output logic      [1:0]  dramKind,        // DRAM type
	output logic             modulePopulated, // Population flag
	input  wire logic        tmoEvent,        // Command timed out pulse
	input  wire logic [7:0]  tmoCommand,      // Code of timed-out command
	output logic      [7:0]  tmoLimit,        // Timeout limit to counters
	input  wire logic        rmwValid,        // Block RMW entry valid
	input  wire logic [10:0] rmwEntry,        // Block RMW entry read
	input  wire logic [26:0] rmwAddr,         // Block RMW block address
	output logic             bsReq,           // Block-state array request
	output logic             bsWrite,         // Array write when high
	output logic      [26:0] bsAddr,          // Array block address
	output logic      [10:0] bsWData,         // Array write pattern
	input  wire logic        bsAck,           // Array done
	input  wire logic [10:0] bsRData,         // Array read pattern
	output logic             nvReq,           // Nonvolatile request
	output logic             nvWrite,         // Nonvolatile write when high
	output logic      [10:0] nvAddr,          // Nonvolatile location
	output logic      [7:0]  nvWData,         // Nonvolatile write byte
	input  wire logic        nvAck,           // Nonvolatile done
	input  wire logic [7:0]  nvRData,         // Nonvolatile read byte
	input  wire logic        dataRdValid,     // Data word from DRAM valid
	input  wire logic [31:0] dataRdWord,      // Data word from DRAM
	input  wire logic [6:0]  dataRdChk,       // Stored check bits
	output logic             dataOutValid,    // Checked word valid
	output logic      [31:0] dataOutWord,     // Corrected word
	output logic             dataCorrected,   // Single-bit fixed
	output logic             dataUncorr,      // Uncorrectable
	input  wire logic [31:0] dataWrWord,      // Word to store
	output logic      [6:0]  dataWrChk        // Its check bits
);
	mcs_pkg::mcs_state_t st_q, st_d;
	logic        wr3, wr4, wrBs, wrBa, wrNv, wrTo, idle;
	logic        nvWrReq, nvRdReq, nvWrBlocked, nvLaunch, bsLaunch, trigFire;
	logic        ctl3Sum, ctl4Sum, rmwBad;
	logic [1:0]  wrMode;
	logic [31:0] ctl3Rd, ctl4Rd, bsRdv, baRd, nvRd, toRd, rdMux;
	logic        permit_q, badNv_q, trigEn_q, trigPulse_q;
	logic [6:0]  flt_q;
	logic [14:0] trigCfg_q;
	logic        diag_q, chkDis_q, pop_q, rmwErr_q, ownSeq_q, pe_q, bsWr_q, nvWr_q;
	logic [4:0]  size_q, dChk_q;
	logic [1:0]  kind_q, code_q, mode_q;
	logic [3:0]  id_q;
	logic [10:0] bsRd_q, bsWData_q, nvAddr_q;
	logic [26:0] blkAddr_q;
	logic [7:0]  nvData_q, tmoCmd_q, tmoLim_q;
	logic        tmoFlag_q;
	logic [31:0] rdData_q, dOut_q;
	logic        rdValid_q, dOutV_q, dCor_q, dUnc_q;
	logic [6:0]  dWrChk_q;

	mcs_ecc_if eif ();

	// Check-code unit hookup
	assign eif.dWrWord = dataWrWord;
	assign eif.dRdWord = dataRdWord;
	assign eif.dRdChk = dataRdChk;
	assign eif.bsGenValue = {code_q, id_q};
	assign eif.bsGenAddr = blkAddr_q;
	assign eif.rmwEntry = rmwEntry;
	assign eif.rmwAddr = rmwAddr;
	mcs_ecc u_ecc (
		.eb (eif.ecc)
	);

	// Address decode and launch conditions
	assign wr3 = regWrEn && (regAddr == mcs_pkg::OFF_CTL3);
	assign wr4 = regWrEn && (regAddr == mcs_pkg::OFF_CTL4);
	assign wrBs = regWrEn && (regAddr == mcs_pkg::OFF_BSDIRECT);
	assign wrBa = regWrEn && (regAddr == mcs_pkg::OFF_BSTARGET);
	assign wrNv = regWrEn && (regAddr == mcs_pkg::OFF_NVCTL);
	assign wrTo = regWrEn && (regAddr == mcs_pkg::OFF_TMO);
	assign idle = (st_q == mcs_pkg::ST_IDLE);
	assign wrMode = regWrData[mcs_pkg::BS_MODE_HI:mcs_pkg::BS_MODE_LO];
	assign nvWrReq = wrNv && regWrData[mcs_pkg::NV_WSTART];
	assign nvRdReq = wrNv && regWrData[mcs_pkg::NV_RSTART] && !regWrData[mcs_pkg::NV_WSTART];
	assign nvWrBlocked = nvWrReq && !permit_q;
	assign nvLaunch = idle && ((nvWrReq && permit_q) || nvRdReq);
	assign bsLaunch = idle && wrBs && regWrData[mcs_pkg::BS_PE]
		&& ((wrMode == mcs_pkg::BSM_READ) || (wrMode == mcs_pkg::BSM_WRITE));
	assign rmwBad = rmwValid && eif.bsChkErr && !chkDis_q;
	assign trigFire = trigEn_q && (|(trigCond & trigCfg_q[13:0]));

	// Error summaries
	// control three summary
	assign ctl3Sum = badNv_q || (|flt_q);
	assign ctl4Sum = rmwErr_q || ownSeq_q || becErrPending;

	// Read images, reserved bits zero
	// reserved read zero
	assign ctl3Rd = {ctl3Sum, permit_q, badNv_q, 6'h00, flt_q, trigEn_q, trigCfg_q};
	assign ctl4Rd = {ctl4Sum, diag_q, chkDis_q, 6'h00, size_q, kind_q, pop_q, rmwErr_q,
		2'h0, ownSeq_q, code_q, id_q, dChk_q};
	assign bsRdv = {pe_q, mode_q, 18'h00000, bsRd_q};
	assign baRd = {blkAddr_q, 5'h00};
	assign nvRd = {(st_q == mcs_pkg::ST_NV) && nvWr_q, (st_q == mcs_pkg::ST_NV) && !nvWr_q,
		3'h0, nvAddr_q, 8'h00, nvData_q};
	assign toRd = {tmoFlag_q, 15'h0000, tmoLim_q, tmoCmd_q};
	assign rdMux = (regAddr == mcs_pkg::OFF_CTL3) ? ctl3Rd :
		(regAddr == mcs_pkg::OFF_CTL4) ? ctl4Rd :
		(regAddr == mcs_pkg::OFF_BSDIRECT) ? bsRdv :
		(regAddr == mcs_pkg::OFF_BSTARGET) ? baRd :
		(regAddr == mcs_pkg::OFF_NVCTL) ? nvRd :
		(regAddr == mcs_pkg::OFF_TMO) ? toRd : 32'h00000000;

	// Access sequencer next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			mcs_pkg::ST_IDLE: begin
				if (bsLaunch) st_d = mcs_pkg::ST_BS;
				else if (nvLaunch) st_d = mcs_pkg::ST_NV;
			end
			mcs_pkg::ST_BS: if (bsAck) st_d = mcs_pkg::ST_IDLE;
			mcs_pkg::ST_NV: if (nvAck) st_d = mcs_pkg::ST_IDLE;
			default: st_d = mcs_pkg::ST_IDLE;
		endcase
	end

	// Sequencer state and read port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= mcs_pkg::ST_IDLE;
			rdData_q <= 32'h00000000;
			rdValid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rdData_q <= regRdEn ? rdMux : rdData_q;
			rdValid_q <= regRdEn;
		end
	end

	// Control three
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			permit_q <= 1'b0;
			badNv_q <= 1'b0;
			flt_q <= 7'h00;
			trigEn_q <= 1'b0;
			trigCfg_q <= mcs_pkg::TRIGCFG_RST;
			trigPulse_q <= 1'b0;
		end else begin
			permit_q <= wr3 ? regWrData[mcs_pkg::C3_PERMIT] : permit_q;
			badNv_q <= nvWrBlocked || (badNv_q && !(wr3 && regWrData[mcs_pkg::C3_BADNV]));
			flt_q <= faultSet | (flt_q & ~(wr3 ? regWrData[mcs_pkg::C3_FLT_HI:mcs_pkg::C3_FLT_LO]
				: 7'h00));
			trigEn_q <= wr3 ? regWrData[mcs_pkg::C3_TRIGEN]
				: (trigEn_q && !(trigFire && trigCfg_q[14]));
			trigCfg_q <= wr3 ? regWrData[mcs_pkg::C3_TRIGCFG_HI:0] : trigCfg_q;
			trigPulse_q <= trigFire;
		end
	end

	// Control four
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{diag_q, chkDis_q, pop_q, rmwErr_q, ownSeq_q} <= 5'h00;
			{size_q, kind_q, code_q, id_q, dChk_q} <= 18'h00000;
		end else begin
			if (wr4) begin
				diag_q <= regWrData[mcs_pkg::C4_DIAG];
				chkDis_q <= regWrData[mcs_pkg::C4_CHKDIS];
				size_q <= regWrData[mcs_pkg::C4_SIZE_HI:mcs_pkg::C4_SIZE_LO];
				kind_q <= regWrData[mcs_pkg::C4_KIND_HI:mcs_pkg::C4_KIND_LO];
				pop_q <= regWrData[mcs_pkg::C4_POP];
				code_q <= regWrData[mcs_pkg::C4_CODE_HI:mcs_pkg::C4_CODE_LO];
				id_q <= regWrData[mcs_pkg::C4_ID_HI:mcs_pkg::C4_ID_LO];
				dChk_q <= regWrData[mcs_pkg::C4_CHK_HI:0];
			end
			rmwErr_q <= rmwBad || (rmwErr_q && !(wr4 && regWrData[mcs_pkg::C4_RMWERR]));
			ownSeq_q <= protoViolation || (ownSeq_q && !(wr4 && regWrData[mcs_pkg::C4_OWNSEQ]));
		end
	end

	// Direct block-state port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{pe_q, mode_q, bsWr_q} <= 4'h0;
			bsRd_q <= 11'h000;
			bsWData_q <= 11'h000;
			blkAddr_q <= 27'h0000000;
		end else begin
			pe_q <= wrBs ? regWrData[mcs_pkg::BS_PE] : pe_q;
			mode_q <= wrBs ? wrMode : mode_q;
			blkAddr_q <= wrBa ? regWrData[31:mcs_pkg::BA_LO] : blkAddr_q;
			if (bsLaunch) begin
				bsWr_q <= (wrMode == mcs_pkg::BSM_WRITE);
				bsWData_q <= {code_q, id_q, diag_q ? dChk_q : eif.bsGenChk};
			end
			if ((st_q == mcs_pkg::ST_BS) && bsAck && !bsWr_q) bsRd_q <= bsRData;
		end
	end

	// Nonvolatile access and timeout registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			nvAddr_q <= 11'h000;
			nvData_q <= 8'h00;
			nvWr_q <= 1'b0;
			tmoFlag_q <= 1'b0;
			tmoCmd_q <= 8'h00;
			tmoLim_q <= mcs_pkg::TO_LIM_RST;
		end else begin
			if (wrNv) begin
				nvAddr_q <= regWrData[mcs_pkg::NV_ADDR_HI:mcs_pkg::NV_ADDR_LO];
				nvData_q <= regWrData[mcs_pkg::NV_DATA_HI:0];
			end else if ((st_q == mcs_pkg::ST_NV) && nvAck && !nvWr_q) begin
				nvData_q <= nvRData;
			end
			if (nvLaunch) nvWr_q <= nvWrReq;
			tmoFlag_q <= tmoEvent || (tmoFlag_q && !(wrTo && regWrData[mcs_pkg::TO_FLAG]));
			if (tmoEvent && !tmoFlag_q) tmoCmd_q <= tmoCommand;
			tmoLim_q <= wrTo ? regWrData[mcs_pkg::TO_LIM_HI:mcs_pkg::TO_LIM_LO] : tmoLim_q;
		end
	end

	// Checked data path
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{dOutV_q, dCor_q, dUnc_q} <= 3'h0;
			dOut_q <= 32'h00000000;
			dWrChk_q <= 7'h00;
		end else begin
			dOutV_q <= dataRdValid;
			dOut_q <= eif.dFixed;
			dCor_q <= dataRdValid && eif.dSingle;
			dUnc_q <= dataRdValid && eif.dUncorr;
			dWrChk_q <= eif.dWrChk;
		end
	end

	// Outputs
	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
	assign trigPulse = trigPulse_q;
	assign memSizeUpper = size_q;
	assign dramKind = kind_q;
	assign modulePopulated = pop_q;
	assign tmoLimit = tmoLim_q;
	assign bsReq = (st_q == mcs_pkg::ST_BS);
	assign bsWrite = bsWr_q;
	assign bsAddr = blkAddr_q;
	assign bsWData = bsWData_q;
	assign nvReq = (st_q == mcs_pkg::ST_NV);
	assign nvWrite = nvWr_q;
	assign nvAddr = nvAddr_q;
	assign nvWData = nvData_q;
	assign dataOutValid = dOutV_q;
	assign dataOutWord = dOut_q;
	assign dataCorrected = dCor_q;
	assign dataUncorr = dUnc_q;
	assign dataWrChk = dWrChk_q;

	// Checks
	property p_ctl3_sum;
		@(posedge sys_clk) disable iff (!resetn)
		(regRdEn && regAddr == mcs_pkg::OFF_CTL3) |=>
			regRdData[31] == ($past(badNv_q) || ($past(flt_q) != 7'h00));
	endproperty
	a_ctl3_sum: assert property (p_ctl3_sum) else $error("ctl3 summary wrong");
	property p_ctl4_sum;
		@(posedge sys_clk) disable iff (!resetn)
		(regRdEn && regAddr == mcs_pkg::OFF_CTL4 && becErrPending) |=> regRdData[31];
	endproperty
	a_ctl4_sum: assert property (p_ctl4_sum) else $error("ctl4 summary wrong");
	property p_nv_permit;
		@(posedge sys_clk) disable iff (!resetn)
		(nvReq && nvWrite) |-> $past(permit_q, 1) || $past(nvReq, 1);
	endproperty
	a_nv_permit: assert property (p_nv_permit) else $error("nv write without permit");
	property p_nv_refuse;
		@(posedge sys_clk) disable iff (!resetn)
		(wrNv && regWrData[31] && !permit_q) |=> badNv_q;
	endproperty
	a_nv_refuse: assert property (p_nv_refuse) else $error("refused write not flagged");
	property p_fault_set;
		@(posedge sys_clk) disable iff (!resetn)
		faultSet[0] |=> flt_q[0];
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault bit lost");
	property p_rmw_err;
		@(posedge sys_clk) disable iff (!resetn)
		(rmwValid && eif.bsChkErr && !chkDis_q) |=> rmwErr_q;
	endproperty
	a_rmw_err: assert property (p_rmw_err) else $error("rmw error not set");
	property p_own_seq;
		@(posedge sys_clk) disable iff (!resetn)
		protoViolation |=> ownSeq_q ##1 (ownSeq_q || $past(wr4, 1));
	endproperty
	a_own_seq: assert property (p_own_seq) else $error("protocol error lost");
	property p_bs_hold;
		@(posedge sys_clk) disable iff (!resetn)
		(bsReq && !bsAck) |=> bsReq && $stable(bsWData) && $stable(bsWrite);
	endproperty
	a_bs_hold: assert property (p_bs_hold) else $error("block request dropped");
	property p_blk_low;
		@(posedge sys_clk) disable iff (!resetn)
		(regRdEn && regAddr == mcs_pkg::OFF_BSTARGET) |=> regRdData[4:0] == 5'h00;
	endproperty
	a_blk_low: assert property (p_blk_low) else $error("address low bits set");
	property p_w1c_zero;
		@(posedge sys_clk) disable iff (!resetn)
		(wr3 && !regWrData[29] && badNv_q) |=> badNv_q;
	endproperty
	a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared bit");
endmodule : mcs_regs
`default_nettype wire

// file: tb/mcs_store_model.sv
// Behavioural array on the far side of the direct access ports
`timescale 1ns/1ps
`default_nettype none
module mcs_store_model #(
	parameter int W   = 8, // Pattern width
	parameter int LAT = 0  // Extra wait cycles
) (
	input  wire logic         sys_clk, // Clock
	input  wire logic         resetn,  // Reset, active low
	input  wire logic         req,     // Access request
	input  wire logic         wr,      // Write when high
	input  wire logic [W-1:0] wData,   // Write pattern
	output logic              ack,     // Done pulse
	output logic      [W-1:0] rData    // Read pattern
);
	logic [W-1:0] memQ;
	int           cnt;
	// Answer after LAT cycles, scramble read data outside the answer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ack <= 1'b0;
			cnt <= 0;
			memQ <= '0;
			rData <= '0;
		end else if (req && !ack && cnt >= LAT) begin
			ack <= 1'b1;
			cnt <= 0;
			memQ <= wr ? wData : memQ;
			rData <= wr ? ~memQ : memQ;
		end else begin
			ack <= 1'b0;
			cnt <= (req && !ack) ? cnt + 1 : 0;
			rData <= ~rData;
		end
	end
endmodule : mcs_store_model
`default_nettype wire

// file: tb/mcs_regs_tb.sv
// Self-checking bench for the memory control and status registers
`timescale 1ns/1ps
`default_nettype none
module mcs_regs_tb;
	logic sys_clk = 1'b0, resetn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00, tmoCommand = 8'h00, nvRData, tmoLimit, nvWData;
	logic [31:0] regWrData = 32'h0, dataRdWord = 32'h0, dataWrWord = 32'h0;
	logic [31:0] regRdData, dataOutWord, v, r;
	logic [6:0] faultSet = 7'h00, dataRdChk = 7'h00, dataWrChk;
	logic protoViolation = 1'b0, becErrPending = 1'b0, tmoEvent = 1'b0, rmwValid = 1'b0;
	logic dataRdValid = 1'b0, regRdValid, trigPulse, modulePopulated, bsReq, bsWrite, bsAck;
	logic nvReq, nvWrite, nvAck, dataOutValid, dataCorrected, dataUncorr;
	logic [13:0] trigCond = 14'h0;
	logic [4:0] memSizeUpper;
	logic [1:0] dramKind;
	logic [10:0] rmwEntry = 11'h0, nvAddr, bsWData, bsRData;
	logic [26:0] rmwAddr = 27'h0, bsAddr;
	integer mismatches = 0, checks = 0, seed = 1, i;
	// Clock at 100 MHz
	always #5 sys_clk = ~sys_clk;
	mcs_regs u_mcs_regs (.*);
	mcs_store_model #(.W(11), .LAT(0)) u_mcs_store_model (.sys_clk(sys_clk),
		.resetn(resetn), .req(bsReq), .wr(bsWrite), .wData(bsWData), .ack(bsAck),
		.rData(bsRData));
	mcs_store_model #(.W(8), .LAT(3)) u_mcs_store_model_nv (.sys_clk(sys_clk),
		.resetn(resetn), .req(nvReq), .wr(nvWrite), .wData(nvWData), .ack(nvAck),
		.rData(nvRData));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk);
		regWrEn = 1'b0;
		@(negedge sys_clk); // Idle edge between strobes
	endtask : wr
	task automatic rd(input logic [7:0] a);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk);
		regRdEn = 1'b0;
		@(negedge sys_clk); // Idle edge between strobes
	endtask : rd
	task automatic waitIdle();
		for (i = 0; i < 40 && (bsReq || nvReq); i++) @(negedge sys_clk);
		if (i == 40) begin
			mismatches++;
			summarize();
		end
	endtask : waitIdle
	initial begin
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		rd(8'h60); chk("ctl4", regRdData, 32'h0);
		rd(8'h74); chk("tmo", regRdData, 32'h0000FF00);
		rd(8'h40); chk("unmapped", regRdData, 32'h0);
		faultSet = 7'h55;
		@(negedge sys_clk);
		faultSet = 7'h00;
		@(negedge sys_clk);
		rd(8'h5C); chk("ctl3", regRdData, 32'h80550000);
		wr(8'h5C, 32'h00050000);
		rd(8'h5C); chk("ctl3", regRdData, 32'h80500000);
		wr(8'h5C, 32'h00500000);
		wr(8'h70, 32'h812300A5); chk("nvReq", 32'(nvReq), 32'h0);
		@(negedge sys_clk);
		rd(8'h5C); chk("ctl3", regRdData, 32'hA0000000);
		wr(8'h5C, 32'h60000000);
		wr(8'h70, 32'h812300A5); chk("nvReq", 32'(nvReq), 32'h1);
		chk("nvPort", 32'({nvWrite, nvAddr, nvWData}), 32'h923A5);
		waitIdle();
		wr(8'h70, 32'h40230000);
		waitIdle();
		rd(8'h70); chk("nvCtl", regRdData, 32'h002300A5);
		v = ($random(seed) & 32'h007F87FF) | 32'h40000000;
		wr(8'h60, v);
		chk("ctl4Out", 32'({memSizeUpper, dramKind, modulePopulated}), v[22:15]);
		protoViolation = 1'b1;
		@(negedge sys_clk);
		protoViolation = 1'b0;
		wr(8'h60, v);
		rd(8'h60); chk("ctl4", regRdData, v | 32'h80000800);
		wr(8'h60, v | 32'h800);
		rd(8'h60); chk("ctl4", regRdData, v);
		becErrPending = 1'b1;
		rd(8'h60); chk("ctl4", regRdData, v | 32'h80000000);
		becErrPending = 1'b0;
		// bad entry check sets sticky bit
		rmwEntry = 11'h01F;
		rmwValid = 1'b1;
		@(negedge sys_clk);
		rmwValid = 1'b0;
		rd(8'h60); chk("ctl4", regRdData, v | 32'h80004000);
		wr(8'h60, v | 32'h4000);
		r = $random(seed);
		wr(8'h6C, r);
		rd(8'h6C); chk("block_state_target_address", regRdData, r & 32'hFFFFFFE0);
		wr(8'h68, 32'h80000000); chk("bsReq", 32'(bsReq), 32'h0);
		wr(8'h68, 32'hC0000000); chk("bsAddr", 32'(bsAddr), r >> 5);
		chk("bsWData", 32'(bsWData), v & 32'h7FF);
		chk("bsWrite", 32'({bsReq, bsWrite}), 32'h3);
		waitIdle();
		wr(8'h68, 32'hA0000000);
		waitIdle();
		rd(8'h68); chk("block_state_direct_control", regRdData, 32'hA0000000 | (v & 32'h7FF));
		// one flip fixed, two flips flagged
		for (int k = 1; k < 3; k++) begin
			r = $random(seed);
			dataWrWord = r;
			@(negedge sys_clk);
			dataRdWord = r ^ (k == 1 ? 32'h00010000 : 32'h00000300);
			dataRdChk = dataWrChk;
			dataRdValid = 1'b1;
			@(negedge sys_clk);
			dataRdValid = 1'b0;
			chk("eccValid", 32'(dataOutValid), 32'h1);
			chk("eccFlags", 32'({dataCorrected, dataUncorr}), k == 1 ? 32'h2 : 32'h1);
			if (k == 1) chk("eccWord", dataOutWord, r);
		end
		dataRdWord = 32'h0;
		dataRdChk = 7'h00;
		dataRdValid = 1'b1;
		@(negedge sys_clk);
		dataRdValid = 1'b0;
		chk("eccZero", 32'(dataUncorr), 32'h1);
		tmoCommand = 8'($random(seed));
		tmoEvent = 1'b1;
		@(negedge sys_clk);
		tmoEvent = 1'b0;
		rd(8'h74); chk("tmo", regRdData, 32'h8000FF00 | tmoCommand);
		wr(8'h74, 32'h80003C00); chk("tmoLimit", 32'(tmoLimit), 32'h3C);
		rd(8'h74); chk("tmo", regRdData, 32'h00003C00 | tmoCommand);
		wr(8'h5C, 32'h00008001);
		trigCond = 14'h0001;
		@(negedge sys_clk);
		chk("trigPulse", 32'(trigPulse), 32'h1);
		wr(8'h5C, 32'h0000C001);
		rd(8'h5C); chk("ctl3", regRdData, 32'h00004001);
		chk("trigPulse", 32'(trigPulse), 32'h0);
		summarize();
	end
endmodule : mcs_regs_tb
`default_nettype wire
